// file: tb/host_model.sv
`timescale 1ns/1ps
module host_model (
	input wire logic clk,
	output logic [7:0] regAddr,
	output logic [31:0] regWrData,
	output logic regWr,
	output logic regRd,
	input wire logic [31:0] regRdData
);
	// bus idle at time zero
	initial begin
		regWr = 1'h0;
		regRd = 1'h0;
		regAddr = 8'h0;
		regWrData = 32'h0;
	end

	// one write; callers keep delay values in range except on purpose
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'h1;
		@(posedge clk);
		regWr <= 1'h0;
		regWrData <= ~d; // stale data must not look valid
	endtask

	// data is taken in the one cycle it stands
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		regAddr <= a;
		regRd <= 1'h1;
		@(posedge clk);
		regRd <= 1'h0;
		#1 d = regRdData;
	endtask
endmodule

// file: tb/powerup_and_status_led_control_bench.sv
`timescale 1ns/1ps
`include "powerup_consts.svh"
module powerup_and_status_led_control_bench;
	logic clk, reset_n, clkEn, statusInd, ampReq, motorVoltPin, extPwrPin;
	logic regWr, regRd, statusLed, ampEnable, startupDone, err29, irq, done2;
	logic [7:0] regAddr;
	logic [31:0] regWrData, regRdData, d;
	logic [4:0] auxOut;
	int errors, tests_run, cyc;

	powerup_and_status_led_control #(.MS_CYCLES(4), .DELAY_DEFAULT(16'sh0002)) dut (.*);
	// negative delay with the supply option in mind: wait for voltage
	powerup_and_status_led_control #(.MS_CYCLES(4), .DELAY_DEFAULT(-16'sh0003)) dut2 (
		.*, .regRdData(), .statusLed(), .auxOut(), .ampEnable(),
		.startupDone(done2), .err29(), .irq());
	host_model host (.*);

	initial begin
		clk = 1'h0;
		forever #50 clk = ~clk;
	end

	// a hang counts as a mismatch
	always @(posedge clk) begin
		cyc++;
		if (cyc == 4000) begin
			errors++;
			$display("unexpected at %0t: timeout", $time);
			stop_test;
		end
	end

	task check(input logic c, input string m);
		tests_run++;
		if (c !== 1'h1) begin
			errors++;
			$display("unexpected at %0t: %s", $time, m);
		end
	endtask

	task stop_test;
		$display("errors %0d tests_run %0d", errors, tests_run);
		if (errors == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task t_regs;
		host.rd(`PWR_REG_CTRL, d);
		check(d === 32'h0, "ctrl reset");
		host.rd(`PWR_REG_DELAY, d);
		check(d === 32'h2, "delay reset");
		host.rd(8'h14, d);
		check(d === 32'h0, "unmapped read");
		host.wr(`PWR_REG_DELAY, 32'h1771);
		host.rd(`PWR_REG_DELAY, d);
		check(d === 32'h2, "out of range delay taken");
		host.wr(`PWR_REG_DELAY, 32'hffffec78);
		host.rd(`PWR_REG_DELAY, d);
		check(d === 32'hffffec78, "negative delay readback");
		// the 2 ms start-up is over: done alone in status and events
		host.rd(`PWR_REG_STATUS, d);
		check(d === 32'h1, "status after start-up");
		host.rd(`PWR_REG_IRQ_STAT, d);
		check(d === 32'h1, "done event not sticky");
	endtask

	task t_led;
		@(posedge clk);
		statusInd <= 1'h1;
		for (int i = 1; i <= 5; i++) begin
			host.wr(`PWR_REG_CTRL, 32'h1 | (i << 2));
			repeat (2) @(posedge clk);
			#1;
			check(statusLed === 1'h0, "led not dark");
			check(auxOut === 5'h1 << (i - 1), "aux route");
		end
		host.rd(`PWR_REG_CTRL, d);
		check(d === 32'h15, "ctrl readback");
		host.wr(`PWR_REG_CTRL, 32'h18);
		host.rd(`PWR_REG_CTRL, d);
		check(d === 32'h14, "bad aux select taken");
		check(statusLed === 1'h1, "led not back");
	endtask

	task t_ext;
		@(posedge clk);
		ampReq <= 1'h1;
		host.wr(`PWR_REG_IRQ_MASK, 32'h2);
		host.wr(`PWR_REG_CTRL, 32'h2);
		repeat (5) @(posedge clk);
		#1;
		check(err29 === 1'h1 && ampEnable === 1'h0, "no supply error");
		check(irq === 1'h1, "error irq");
		@(posedge clk);
		extPwrPin <= 1'h1;
		repeat (5) @(posedge clk);
		host.wr(`PWR_REG_IRQ_STAT, 32'h2);
		#1;
		check(ampEnable === 1'h1 && err29 === 1'h0, "amp with supply");
		repeat (2) @(posedge clk);
		#1;
		check(irq === 1'h0, "irq not cleared");
		// clkEn low freezes the registers, so this write is lost
		@(posedge clk);
		clkEn <= 1'h0;
		host.wr(`PWR_REG_CTRL, 32'h0);
		clkEn <= 1'h1;
		host.rd(`PWR_REG_CTRL, d);
		check(d === 32'h2, "option readback");
	endtask

	// count edges from release to done on both devices
	task automatic startup(input logic mv, input int lo2, input int hi2);
		int n1, n2;
		n1 = 0;
		n2 = 0;
		@(posedge clk);
		motorVoltPin <= mv;
		reset_n <= 1'h0;
		repeat (2) @(posedge clk);
		reset_n <= 1'h1;
		for (int i = 1; i < 20; i++) begin
			@(posedge clk);
			#1;
			if (startupDone === 1'h1 && n1 == 0) n1 = i;
			if (done2 === 1'h1 && n2 == 0) n2 = i;
		end
		// i=1 is the load edge, then 2 ms of 4 cycles: done at i=9
		check(n1 == 9, "fixed delay length");
		check(n2 >= lo2 && n2 <= hi2, "voltage wait length");
	endtask

	initial begin
		clkEn = 1'h1;
		reset_n = 1'h0;
		statusInd = 1'h0;
		ampReq = 1'h0;
		motorVoltPin = 1'h0;
		extPwrPin = 1'h0;
		errors = 0;
		tests_run = 0;
		cyc = 0;
		repeat (8) @(posedge clk);
		reset_n <= 1'h1;
		t_regs;
		t_led;
		t_ext;
		startup(1'h0, 13, 13);
		startup(1'h1, 3, 3);
		stop_test;
	end
endmodule

bind powerup_and_status_led_control powerup_sva #(.AUX_N(AUX_N)) chk (.*);

// file: tb/powerup_sva.sv
`timescale 1ns/1ps
module powerup_sva #(
	parameter int AUX_N = 5
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic regRd,
	input wire logic [31:0] regRdData,
	input wire logic statusInd,
	input wire logic ampReq,
	input wire logic extPwrPin,
	input wire logic statusLed,
	input wire logic [AUX_N-1:0] auxOut,
	input wire logic ampEnable,
	input wire logic startupDone,
	input wire logic err29
);
	// one clock domain, so clock and reset are given once
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);

	property p_led; statusLed |-> $past(statusInd); endproperty
	a_led: assert property (p_led) else $error("led lit without indication");
	property p_aux; $onehot0(auxOut); endproperty
	a_aux: assert property (p_aux) else $error("two aux pins active");
	property p_idle; !startupDone |-> !ampEnable && !err29; endproperty
	a_idle: assert property (p_idle) else $error("amp or error before done");
	property p_amp; ampEnable |-> $past(ampReq) && !err29; endproperty
	a_amp: assert property (p_amp) else $error("amp on without request");
	// supply present long enough for the synchroniser means no error
	property p_err; extPwrPin [*4] |=> !err29; endproperty
	a_err: assert property (p_err) else $error("error with supply present");
	property p_ampon; (startupDone && ampReq && extPwrPin) [*4] |=> ampEnable; endproperty
	a_ampon: assert property (p_ampon) else $error("amp held off");
	property p_keep; startupDone |=> startupDone; endproperty
	a_keep: assert property (p_keep) else $error("done dropped");
	property p_rd; !$past(regRd) |-> regRdData == 32'h0; endproperty
	a_rd: assert property (p_rd) else $error("read data outside slot");
endmodule

// file: verilog/powerup_and_status_led_control.sv
// Behaviour
// [RL1] LED force-off bit: 0 normal, 1 dark
// [RL2] force-off leaves auxiliary status outputs alone
// [RL3] force-off bit reads back 0 or 1
// [RL4] delay is signed ms, -5000 to 5000
// [RL5] positive delay waits exactly that many ms
// [RL6] negative delay waits voltage, bounded by magnitude
// [RL7] delay reads back the stored ms value
// [RL8] external-power option gates amplifier enable
// [RL9] missing external supply: amps off, error 29
// [RL10] external-power option resets to 0, reads back
// [RL11] host picks longer negative delay with option
// [RL12] aux select defaults 0; 1-5 route LED
// [RL13] LED gated by force-off; check after delay
//
// Strobed register access and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "powerup_consts.svh"

module powerup_and_status_led_control #(
	parameter int MS_CYCLES = `PWR_MS_NS / `PWR_CLK_NS,
	parameter logic signed [15:0] DELAY_DEFAULT = 16'sh0000,
	parameter int AUX_N = 5
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic clkEn,
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [31:0] regRdData,
	input wire logic statusInd,
	input wire logic ampReq,
	input wire logic motorVoltPin,
	input wire logic extPwrPin,
	output logic statusLed,
	output logic [AUX_N-1:0] auxOut,
	output logic ampEnable,
	output logic startupDone,
	output logic err29,
	output logic irq
);

	// counter width for one millisecond of clock cycles
	localparam int MCW = $clog2(MS_CYCLES + 1);

	// pin synchronisers; only the second stage is used
	// both pins are asynchronous, so nothing reads the first stage
	logic mvMeta_q, mvSync_q, epMeta_q, epSync_q;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			mvMeta_q <= 1'b0;
			mvSync_q <= 1'b0;
			epMeta_q <= 1'b0;
			epSync_q <= 1'b0;
		end else if (clkEn) begin
			mvMeta_q <= motorVoltPin;
			mvSync_q <= mvMeta_q;
			epMeta_q <= extPwrPin;
			epSync_q <= epMeta_q;
		end
	end

	// register file: settings, sticky events and their next values
	logic noled_q, noled_d;
	logic extPwr_q, extPwr_d;
	logic [2:0] stout_q, stout_d;
	logic signed [15:0] delay_q, delay_d;
	logic [`PWR_IRQ_W-1:0] irqStat_q, irqStat_d;
	logic [`PWR_IRQ_W-1:0] irqMask_q, irqMask_d;
	logic [31:0] rdData_q, rdData_d;
	logic [`PWR_IRQ_W-1:0] irqEvent;
	logic [2:0] wrStout;
	logic signed [15:0] wrDelay;
	logic [31:0] statusWord;

	// settings writes; out-of-range values are dropped so the stored value stays legal
	// a ctrl write with a bad aux select still takes the other two bits
	always_comb begin
		noled_d = noled_q;
		extPwr_d = extPwr_q;
		stout_d = stout_q;
		delay_d = delay_q;
		irqMask_d = irqMask_q;
		wrStout = regWrData[`PWR_CTRL_STOUT_HI:`PWR_CTRL_STOUT_LO];
		wrDelay = regWrData[15:0];
		if (regWr && regAddr == `PWR_REG_CTRL) begin
			noled_d = regWrData[`PWR_CTRL_NOLED]; // see [RL1]
			extPwr_d = regWrData[`PWR_CTRL_EXTPWR]; // see [RL10]
			if (wrStout <= `PWR_STOUT_MAX) begin
				stout_d = wrStout; // see [RL12]
			end
		end
		if (regWr && regAddr == `PWR_REG_DELAY) begin
			// an out-of-range delay leaves the old value in place
			if (wrDelay >= `PWR_DELAY_MIN && wrDelay <= `PWR_DELAY_MAX) begin
				delay_d = wrDelay; // see [RL4]
			end
		end
		if (regWr && regAddr == `PWR_REG_IRQ_MASK) begin
			irqMask_d = regWrData[`PWR_IRQ_W-1:0];
		end
	end

	// sticky events: write one to clear, a new event in the same cycle wins
	// the done and error events come from the next-state logic
	always_comb begin
		irqStat_d = irqStat_q;
		if (regWr && regAddr == `PWR_REG_IRQ_STAT) begin
			irqStat_d = irqStat_q & ~regWrData[`PWR_IRQ_W-1:0];
		end
		irqStat_d = irqStat_d | irqEvent;
	end

	// read mux; data appear the cycle after the strobe, unmapped reads zero
	// reads have no side effects, so software may poll freely
	always_comb begin
		rdData_d = 32'h0000_0000;
		if (regRd) begin
			case (regAddr)
				`PWR_REG_CTRL: begin
					rdData_d[`PWR_CTRL_NOLED] = noled_q; // see [RL3]
					rdData_d[`PWR_CTRL_EXTPWR] = extPwr_q; // see [RL10]
					rdData_d[`PWR_CTRL_STOUT_HI:`PWR_CTRL_STOUT_LO] = stout_q;
				end
				`PWR_REG_DELAY: rdData_d = {{16{delay_q[15]}}, delay_q}; // see [RL7]
				`PWR_REG_STATUS: rdData_d = statusWord;
				`PWR_REG_IRQ_STAT: rdData_d[`PWR_IRQ_W-1:0] = irqStat_q;
				`PWR_REG_IRQ_MASK: rdData_d[`PWR_IRQ_W-1:0] = irqMask_q;
				// unmapped offsets fall through to zero
				default: rdData_d = 32'h0000_0000;
			endcase
		end
	end

	// settings, sticky event and read data registers; clkEn low holds every one of them
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			noled_q <= `PWR_NOLED_RST;
			extPwr_q <= `PWR_EXTPWR_RST;
			stout_q <= `PWR_STOUT_OFF;
			delay_q <= DELAY_DEFAULT;
			irqStat_q <= '0;
			irqMask_q <= '0;
			rdData_q <= 32'h0000_0000;
		end else if (clkEn) begin
			noled_q <= noled_d;
			extPwr_q <= extPwr_d;
			stout_q <= stout_d;
			delay_q <= delay_d;
			irqStat_q <= irqStat_d;
			irqMask_q <= irqMask_d;
			rdData_q <= rdData_d;
		end
	end

	// irq is a level from registers, so it may drive a host pin directly
	assign regRdData = rdData_q;
	assign irq = |(irqStat_q & irqMask_q);

	// start-up sequencer: runs once after every reset
	powerup_pkg::seq_state_t state_q, state_d;
	logic [MCW-1:0] cycCnt_q, cycCnt_d;
	logic [15:0] msLeft_q, msLeft_d;
	logic done_q, done_d;
	logic err_q, err_d;
	logic amp_q, amp_d;
	logic msTick;

	// one pulse per millisecond while waiting
	assign msTick = (cycCnt_q == MCW'(MS_CYCLES - 1));

	// the delay setting is taken once, in the first cycle after reset
	// loading in one cycle keeps later delay writes out of this start-up
	always_comb begin
		state_d = state_q;
		cycCnt_d = cycCnt_q;
		msLeft_d = msLeft_q;
		done_d = done_q;
		case (state_q)
			powerup_pkg::SEQ_LOAD: begin
				cycCnt_d = '0;
				if (delay_q > 16'sh0000) begin
					msLeft_d = delay_q;
					state_d = powerup_pkg::SEQ_WAIT_FIXED;
				end else if (delay_q < 16'sh0000) begin
					// a negative setting bounds the wait by its magnitude
					msLeft_d = 16'(-delay_q);
					state_d = powerup_pkg::SEQ_WAIT_VOLT;
				end else begin
					// zero delay: start-up is finished at once
					done_d = 1'b1;
					state_d = powerup_pkg::SEQ_RUN;
				end
			end
			powerup_pkg::SEQ_WAIT_FIXED, powerup_pkg::SEQ_WAIT_VOLT: begin
				// both waits share the millisecond counter
				cycCnt_d = msTick ? '0 : MCW'(cycCnt_q + 1'b1);
				if (msTick) begin
					msLeft_d = msLeft_q - 16'h0001;
				end
				// fixed wait ends on its last millisecond only
				// running out of time without voltage still finishes start-up
				if (msTick && msLeft_q == 16'h0001) begin // see [RL5]
					done_d = 1'b1;
					state_d = powerup_pkg::SEQ_RUN;
				end
				// voltage wait ends early once the motor voltage is good
				if (state_q == powerup_pkg::SEQ_WAIT_VOLT && mvSync_q) begin // see [RL6]
					done_d = 1'b1;
					state_d = powerup_pkg::SEQ_RUN;
				end
			end
			powerup_pkg::SEQ_RUN: begin
				// done holds until the next reset
				done_d = 1'b1;
			end
			default: begin
				// an illegal state restarts the load
				state_d = powerup_pkg::SEQ_LOAD;
			end
		endcase
	end

	// amplifier gating; external supply checked only once start-up is done
	// so a supply that rises during the delay is not flagged
	// err29 is a level; the sticky copy lives in the interrupt status
	always_comb begin
		err_d = done_q && extPwr_q && !epSync_q; // see [RL9] see [RL13]
		amp_d = done_q && ampReq && !(extPwr_q && !epSync_q); // see [RL8]
	end

	// sequencer and amplifier registers
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= powerup_pkg::SEQ_LOAD;
			cycCnt_q <= '0;
			msLeft_q <= 16'h0000;
			done_q <= 1'b0;
			err_q <= 1'b0;
			amp_q <= 1'b0;
		end else if (clkEn) begin
			state_q <= state_d;
			cycCnt_q <= cycCnt_d;
			msLeft_q <= msLeft_d;
			done_q <= done_d;
			err_q <= err_d;
			amp_q <= amp_d;
		end
	end

	// events: start-up completes, error 29 appears
	// each is a one-cycle pulse into the sticky bits
	assign irqEvent[`PWR_IRQ_DONE] = done_d && !done_q;
	assign irqEvent[`PWR_IRQ_ERR29] = err_d && !err_q;

	// live status word for polling
	always_comb begin
		statusWord = 32'h0000_0000;
		statusWord[`PWR_ST_DONE] = done_q;
		statusWord[`PWR_ST_AMP] = amp_q;
		statusWord[`PWR_ST_ERR29] = err_q;
		statusWord[`PWR_ST_MVOLT] = mvSync_q;
		statusWord[`PWR_ST_EXTPWR] = epSync_q;
	end

	// registered levels, so no glitch reaches the amplifiers
	assign startupDone = done_q;
	assign err29 = err_q;
	assign ampEnable = amp_q;

	// indicator outputs
	// the led is registered so both led and aux share one cycle of latency
	logic led_q, led_d;
	logic [AUX_N-1:0] aux_q, aux_d;

	// led follows the indication unless forced dark
	always_comb begin
		led_d = statusInd && !noled_q; // see [RL1] see [RL13]
	end

	// aux pins ignore the force-off bit on purpose
	// only the selected pin follows the indication
	for (genvar i = 0; i < AUX_N; i++) begin : g_aux
		always_comb begin
			aux_d[i] = statusInd && (stout_q == 3'(i + 1)); // see [RL2] see [RL12]
		end
	end

	// indicator registers
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			led_q <= 1'b0;
			aux_q <= '0;
		end else if (clkEn) begin
			led_q <= led_d;
			aux_q <= aux_d;
		end
	end

	// led and aux pins leave the block straight from flops
	assign statusLed = led_q;
	assign auxOut = aux_q;

endmodule

// file: verilog/powerup_consts.svh
`ifndef POWERUP_CONSTS_SVH
`define POWERUP_CONSTS_SVH

// register byte offsets
`define PWR_REG_CTRL 8'h00
`define PWR_REG_DELAY 8'h04
`define PWR_REG_STATUS 8'h08
`define PWR_REG_IRQ_STAT 8'h0c
`define PWR_REG_IRQ_MASK 8'h10

// control register fields
`define PWR_CTRL_NOLED 0
`define PWR_CTRL_EXTPWR 1
`define PWR_CTRL_STOUT_LO 2
`define PWR_CTRL_STOUT_HI 4

// status register fields
`define PWR_ST_DONE 0
`define PWR_ST_AMP 1
`define PWR_ST_ERR29 2
`define PWR_ST_MVOLT 3
`define PWR_ST_EXTPWR 4

// interrupt bits
`define PWR_IRQ_DONE 0
`define PWR_IRQ_ERR29 1
`define PWR_IRQ_W 2

// setting limits and reset values
`define PWR_DELAY_MIN (-16'sd5000)
`define PWR_DELAY_MAX 16'sd5000
`define PWR_STOUT_MAX 3'h5
`define PWR_STOUT_OFF 3'h0
`define PWR_NOLED_RST 1'b0
`define PWR_EXTPWR_RST 1'b0

// timing: one millisecond and the clock period, both in ns
`define PWR_MS_NS 1000000
`define PWR_CLK_NS 100

`endif

// file: verilog/powerup_pkg.sv
package powerup_pkg;

	// start-up sequencer phases
	typedef enum logic [1:0] {
		SEQ_LOAD,
		SEQ_WAIT_FIXED,
		SEQ_WAIT_VOLT,
		SEQ_RUN
	} seq_state_t;

endpackage
